/* amps_far_side.sv */
/*
  far side model: the outdoor unit answering link requests.
  assumes one request pulse at a time from the bench, all on clk_i.
*/
`timescale 1ns/1ps
module amps_far_side (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic req_i,
  input  wire logic silent_i,
  output logic      odu_response_o,
  output logic      odu_timeout_o
);
  typedef struct packed {
    logic resp;
    logic tmo;
  } amps_far_t;
  amps_far_t st;
  amps_far_t next_st;
  // ----------------------------------------
  // answer or miss one cycle after a request
  // ----------------------------------------
  // silent models a dead or unplugged unit, never a late answer
  always_comb begin
    next_st.resp = req_i & ~silent_i;
    next_st.tmo  = req_i & silent_i;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end
  assign odu_response_o = st.resp;
  assign odu_timeout_o  = st.tmo;
endmodule

/* amps_pkg.sv */
/*
  constants and state type for the alarm monitor and profile store.
  assumes a 10 MHz system clock and a classic wishbone register bus.
*/
package amps_pkg;
  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_MODE   = 8'h04;
  localparam logic [7:0] ADDR_STAT   = 8'h08;
  localparam logic [7:0] ADDR_CLR    = 8'h0C;
  localparam logic [7:0] ADDR_PROF   = 8'h10;
  localparam logic [7:0] ADDR_CNT_LO = 8'h14;
  localparam logic [7:0] ADDR_CNT_HI = 8'h18;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int CFG_W      = 6;
  localparam int CTRL_LBAND = 0;
  localparam int CTRL_RF    = 1;
  localparam int CTRL_EXT   = 2;
  localparam int CTRL_RATE  = 3;
  localparam int CTRL_ODU   = 5;
  localparam logic [CFG_W-1:0] CFG_RST  = 6'h00;
  localparam logic [CFG_W-1:0] TX_MASK  = 6'h03;
  localparam logic [15:0]      MODE_RST = 16'h0000;
  localparam int CLR_IMG    = 8;
  localparam int PROF_SAVE  = 8;
  localparam int PROF_LOAD  = 9;
  localparam int STAT_GEN   = 8;
  localparam int STAT_ERR   = 9;
  localparam int STAT_LAST  = 16;
  // ----------------------------------------
  // alarms, modes, rates
  // ----------------------------------------
  localparam int N_ALM    = 8;
  localparam int ALM_OVF  = 0;
  localparam int ALM_CLK  = 1;
  localparam int ALM_SYN  = 2;
  localparam int ALM_RFO  = 3;
  localparam int ALM_ODUL = 4;
  localparam int ALM_FP   = 5;
  localparam int ALM_SUM  = 6;
  localparam int ALM_ASM  = 7;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_MASK   = 2'h1;
  localparam logic [1:0] MODE_FORCE  = 2'h2;
  localparam logic [1:0] RATE_FAST   = 2'h0;
  localparam logic [1:0] RATE_MID    = 2'h1;
  localparam logic [7:0] CNT_MAX     = 8'hFF;
  localparam logic [3:0] ODU_MISS_LIMIT = 4'hC;
  localparam int N_SLOTS = 48;
  localparam logic [5:0] SLOT_LAST = 6'h2F;
  // ----------------------------------------
  // buffer window, in tenths of a percent
  // ----------------------------------------
  localparam int LVL_W = 11;
  localparam logic [31:0] BUF_DEPTH = 32'h400;
  localparam logic [31:0] PM_SCALE  = 32'h3E8;
  localparam logic [31:0] WIN_HI    = 32'h258;
  localparam logic [31:0] LO_FAST   = 32'h190;
  localparam logic [31:0] LO_MID    = 32'h064;
  localparam logic [31:0] LO_SLOW   = 32'h032;
  localparam logic [31:0] SP_FAST   = 32'h1F4;
  localparam logic [31:0] SP_MID    = 32'h0FA;
  localparam logic [31:0] SP_SLOW   = 32'h07D;

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     dat;
    logic [CFG_W-1:0]                cfg;
    logic [15:0]                     mode;
    logic [N_ALM-1:0]                eff;
    logic [N_ALM-1:0][7:0]           cnt;
    logic [3:0]                      miss;
    logic                            fp;
    logic [N_SLOTS-1:0][CFG_W-1:0]   prof;
    logic [N_SLOTS-1:0]              valid;
    logic [5:0]                      last;
    logic                            perr;
    logic                            boot;
    logic                            gen;
    logic                            lband;
    logic                            rf;
    logic [LVL_W-1:0]                sp;
    logic                            nv_wr;
    logic                            img;
  } amps_state_t;
endpackage

/* amps_top.sv */
/*
  alarm supervision, transmit gating and 48-slot profile store.
  assumes all monitor inputs synchronous to clk_i and a classic wishbone master.
*/
`timescale 1ns/1ps

module amps_top
  import amps_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [31:0]      dat_i,
  input  wire logic             we_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             reboot_i,
  input  wire logic             buf_overflow_i,
  input  wire logic [LVL_W-1:0] buf_level_i,
  input  wire logic             synth_fault_i,
  input  wire logic             rf_osc_unlock_i,
  input  wire logic             odu_response_i,
  input  wire logic             odu_timeout_i,
  input  wire logic             odu_mismatch_i,
  input  wire logic [7:0]       odu_alarms_i,
  input  wire logic             assembly_mismatch_i,
  output logic      [N_ALM-1:0] alarm_o,
  output logic                  general_fault_alarm_o,
  output logic                  lband_tx_en_o,
  output logic                  rf_tx_en_o,
  output logic      [LVL_W-1:0] buf_setpoint_o,
  output logic                  nv_global_wr_o,
  output logic      [15:0]      nv_global_data_o,
  output logic                  odu_image_save_o
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return res;
  endfunction

  // rates below 50 Kbps are not covered and fall back to the slowest window
  function automatic logic [31:0] rate_lo(input logic [1:0] rate);
    logic [31:0] lo;
    lo = LO_SLOW;
    if (rate == RATE_FAST) begin
      lo = LO_FAST;
    end else if (rate == RATE_MID) begin
      lo = LO_MID;
    end
    return lo;
  endfunction

  function automatic logic [31:0] rate_sp(input logic [1:0] rate);
    logic [31:0] sp;
    sp = SP_SLOW;
    if (rate == RATE_FAST) begin
      sp = SP_FAST;
    end else if (rate == RATE_MID) begin
      sp = SP_MID;
    end
    return sp;
  endfunction

  amps_state_t      r;
  amps_state_t      n;
  logic             req;
  logic             wr;
  logic [1:0]       rate;
  logic [31:0]      fill_pm;
  logic             in_win;
  logic [N_ALM-1:0] raw;
  logic [N_ALM-1:0] eff_c;
  logic [N_ALM-1:0] clr_c;
  logic [5:0]       pslot;
  logic             psave;
  logic             pload;
  logic             slot_ok;
  logic [31:0]      cfg_m;
  logic [31:0]      mode_m;

  assign req     = cyc_i & stb_i & ~r.ack;
  assign wr      = req & we_i;
  assign rate    = r.cfg[CTRL_RATE +: 2];
  // scaled to tenths of a percent so 12.5 stays exact
  assign fill_pm = (32'(buf_level_i) * PM_SCALE) / BUF_DEPTH;
  assign in_win  = (fill_pm >= rate_lo(rate)) && (fill_pm <= WIN_HI);
  assign clr_c   = (wr && adr_i == ADDR_CLR) ? dat_i[N_ALM-1:0] : '0;
  assign pslot   = dat_i[5:0];
  assign psave   = wr && adr_i == ADDR_PROF && dat_i[PROF_SAVE];
  assign pload   = wr && adr_i == ADDR_PROF && dat_i[PROF_LOAD];
  assign slot_ok = pslot <= SLOT_LAST;
  // merged words kept apart: a function result cannot be part-selected directly
  assign cfg_m   = wmerge(32'(r.cfg), dat_i, sel_i);
  assign mode_m  = wmerge(32'(r.mode), dat_i, sel_i);

  // ----------------------------------------
  // raw alarm conditions
  // ----------------------------------------
  assign raw[ALM_OVF]  = buf_overflow_i;
  assign raw[ALM_CLK]  = r.cfg[CTRL_EXT] & ~in_win;
  assign raw[ALM_SYN]  = synth_fault_i;
  assign raw[ALM_RFO]  = r.cfg[CTRL_RF] & rf_osc_unlock_i;
  assign raw[ALM_ODUL] = r.cfg[CTRL_ODU] & (r.miss >= ODU_MISS_LIMIT);
  assign raw[ALM_FP]   = r.fp;
  assign raw[ALM_SUM]  = |odu_alarms_i;
  assign raw[ALM_ASM]  = assembly_mismatch_i;

  always_comb begin
    for (int i = 0; i < N_ALM; i++) begin
      eff_c[i] = (r.mode[2*i +: 2] == MODE_FORCE) |
                 ((r.mode[2*i +: 2] == MODE_NORMAL) & raw[i]);
    end
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    n       = r;
    n.ack   = req;
    n.dat   = 32'h0000_0000;
    n.nv_wr = 1'b0;
    n.img   = 1'b0;
    n.boot  = reboot_i;
    if (req && !we_i) begin
      unique case (adr_i)
        ADDR_CTRL:   n.dat = 32'(r.cfg);
        ADDR_MODE:   n.dat = 32'(r.mode);
        ADDR_STAT:   n.dat = 32'(r.eff) | (32'(r.gen) << STAT_GEN) | (32'(r.perr) << STAT_ERR) |
                             (32'(r.last) << STAT_LAST);
        ADDR_PROF:   n.dat = 32'(r.last) | (32'(r.perr) << STAT_ERR);
        ADDR_CNT_LO: n.dat = {r.cnt[3], r.cnt[2], r.cnt[1], r.cnt[0]};
        ADDR_CNT_HI: n.dat = {r.cnt[7], r.cnt[6], r.cnt[5], r.cnt[4]};
        default:     n.dat = 32'h0000_0000;
      endcase
    end
    if (wr && adr_i == ADDR_CTRL) begin
      n.cfg = cfg_m[CFG_W-1:0];
    end
    // modes live outside the profiles and are pushed out on every change
    if (wr && adr_i == ADDR_MODE && mode_m[15:0] != r.mode) begin
      n.mode  = mode_m[15:0];
      n.nv_wr = 1'b1;
    end
    // profile store; save wins if both command bits are set
    if (psave) begin
      if (slot_ok) begin
        n.prof[pslot]  = (pslot == 6'h00) ? r.cfg : (r.cfg & ~TX_MASK);
        n.valid[pslot] = 1'b1;
        n.perr         = 1'b0;
      end else begin
        n.perr = 1'b1;
      end
    end else if (pload) begin
      if (slot_ok && r.valid[pslot]) begin
        n.cfg  = r.prof[pslot];
        n.last = pslot;
        n.perr = 1'b0;
      end else begin
        n.perr = 1'b1;
      end
    end
    if (r.boot) begin
      n.last = 6'h00;
      if (r.valid[0]) begin
        n.cfg = r.prof[0];
      end
    end
    // outdoor link: a response restarts the count of missed answers
    if (!r.cfg[CTRL_ODU] || odu_response_i) begin
      n.miss = 4'h0;
    end else if (odu_timeout_i && r.miss < ODU_MISS_LIMIT) begin
      n.miss = r.miss + 4'h1;
    end
    // fingerprint: a mismatch seen in the clearing cycle keeps the flag
    if (wr && adr_i == ADDR_CLR && dat_i[CLR_IMG]) begin
      n.img = 1'b1;
    end
    n.fp  = odu_mismatch_i | (r.fp & ~n.img);
    n.eff = eff_c;
    for (int i = 0; i < N_ALM; i++) begin
      if (eff_c[i] && !r.eff[i]) begin
        n.cnt[i] = (clr_c[i]) ? 8'h01 : ((r.cnt[i] == CNT_MAX) ? CNT_MAX : r.cnt[i] + 8'h01);
      end else if (clr_c[i]) begin
        n.cnt[i] = 8'h00;
      end
    end
    n.gen   = |eff_c;
    n.lband = r.cfg[CTRL_LBAND] & ~eff_c[ALM_SYN];
    n.rf    = r.cfg[CTRL_RF] & ~eff_c[ALM_RFO] & ~eff_c[ALM_ODUL];
    n.sp    = LVL_W'((BUF_DEPTH * rate_sp(rate)) / PM_SCALE);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r      <= '0;
      r.cfg  <= CFG_RST;
      r.mode <= MODE_RST;
      r.boot <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign dat_o                 = r.dat;
  assign ack_o                 = r.ack;
  assign alarm_o               = r.eff;
  assign general_fault_alarm_o = r.gen;
  assign lband_tx_en_o         = r.lband;
  assign rf_tx_en_o            = r.rf;
  assign buf_setpoint_o        = r.sp;
  assign nv_global_wr_o        = r.nv_wr;
  assign nv_global_data_o      = r.mode;
  assign odu_image_save_o      = r.img;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ovf_alarm_a: assert property (buf_overflow_i && r.mode[1:0] == MODE_NORMAL |=> alarm_o[ALM_OVF])
    else $error("overflow alarm not raised");
  clk_internal_a: assert property (!r.cfg[CTRL_EXT] && r.mode[3:2] != MODE_FORCE |=> !alarm_o[ALM_CLK])
    else $error("clock alarm with internal clock");
  lband_block_a: assert property (alarm_o[ALM_SYN] |-> !lband_tx_en_o)
    else $error("lband on during synth alarm");
  rf_block_a: assert property (alarm_o[ALM_RFO] || alarm_o[ALM_ODUL] |-> !rf_tx_en_o)
    else $error("rf on during blocking alarm");
  odu_off_a: assert property (!r.cfg[CTRL_ODU] && r.mode[9:8] == MODE_NORMAL |=> !alarm_o[ALM_ODUL])
    else $error("link alarm while link disabled");
  cnt_sat_a: assert property ($rose(r.eff[0]) && !$past(clr_c[0]) |->
      r.cnt[0] == (($past(r.cnt[0]) == CNT_MAX) ? CNT_MAX : $past(r.cnt[0]) + 8'h01))
    else $error("occurrence count wrong");
  gen_or_a: assert property (general_fault_alarm_o == |alarm_o)
    else $error("general alarm not the or");
  save_txoff_a: assert property (psave && slot_ok && pslot != 6'h00 |=> (r.prof[$past(pslot)] & TX_MASK) == 6'h00)
    else $error("transmit kept in non-boot slot");
  load_bad_a: assert property (pload && !psave && !r.boot && !(slot_ok && r.valid[pslot]) |=> r.perr)
    else $error("invalid load accepted");
  mask_ign_a: assert property (r.mode[1:0] == MODE_MASK |=> !alarm_o[ALM_OVF])
    else $error("masked alarm shown");
endmodule

/* testbench.sv */
/*
  self-checking bench for the alarm monitor and profile store.
  assumes the design's 1-cycle wishbone ack and registered alarm outputs.
*/
`timescale 1ns/1ps
module testbench
  import amps_pkg::*;
  ;
  logic             clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0;
  logic [7:0]       adr_i = 8'h00, odu_alarms_i = 8'h00;
  logic [31:0]      dat_i = 32'h0, dat_o, rd;
  logic [3:0]       sel_i = 4'h0;
  logic             reboot_i = 1'b0, buf_overflow_i = 1'b0, synth_fault_i = 1'b0;
  logic             rf_osc_unlock_i = 1'b0, odu_mismatch_i = 1'b0, assembly_mismatch_i = 1'b0;
  logic             req = 1'b0, silent = 1'b0, exp_a, ack_o, resp, tmo, gen, lband, rfen, nvwr, img;
  logic [LVL_W-1:0] buf_level_i = 11'h000, sp;
  logic [N_ALM-1:0] alarm_o;
  logic [15:0]      nvdata;
  int               num_errors = 0, samples_checked = 0, nv_cnt = 0, img_cnt = 0;
  logic [10:0]      lv_t [10] = '{11'h199, 11'h19A, 11'h267, 11'h268, 11'h066, 11'h067, 11'h033, 11'h034,
                                  11'h033, 11'h000};
  logic [1:0]       rt_t [10] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h0};
  logic             al_t [10] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  amps_top dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .we_i(we_i), .sel_i(sel_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .reboot_i(reboot_i),
    .buf_overflow_i(buf_overflow_i), .buf_level_i(buf_level_i), .synth_fault_i(synth_fault_i),
    .rf_osc_unlock_i(rf_osc_unlock_i), .odu_response_i(resp), .odu_timeout_i(tmo),
    .odu_mismatch_i(odu_mismatch_i), .odu_alarms_i(odu_alarms_i), .assembly_mismatch_i(assembly_mismatch_i),
    .alarm_o(alarm_o), .general_fault_alarm_o(gen), .lband_tx_en_o(lband), .rf_tx_en_o(rfen),
    .buf_setpoint_o(sp), .nv_global_wr_o(nvwr), .nv_global_data_o(nvdata), .odu_image_save_o(img));
  amps_far_side far (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .silent_i(silent),
    .odu_response_o(resp), .odu_timeout_o(tmo));

  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (nvwr === 1'b1)
      nv_cnt++;
    if (img === 1'b1)
      img_cnt++;
  end
  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic wb_cycle(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    adr_i <= a;
    we_i  <= w;
    dat_i <= d;
    sel_i <= 4'hF;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      $display("ERROR ack expected 1 seen %b", ack_o);
      num_errors++;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask
  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask
  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    wb_cycle(a, 1'b0, 32'h0, q);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      num_errors++;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // n requests per call; a free edge between requests keeps each req a one-cycle pulse
  task automatic odu_req(input logic s, input int n);
    repeat (n) begin
      @(posedge clk_i);
      silent <= s;
      req    <= 1'b1;
      @(posedge clk_i);
      req    <= 1'b0;
    end
  endtask
  function automatic logic [31:0] sp_exp(input logic [1:0] r);
    return (r == RATE_FAST ? SP_FAST : r == RATE_MID ? SP_MID : SP_SLOW) * BUF_DEPTH / PM_SCALE;
  endfunction
  task automatic end_of_test();
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(2);
    chk("alarm_o", 32'h0, alarm_o);
    wb_read(ADDR_STAT, rd);
    chk("stat", 32'h0, rd & 32'h1FF);
    wb_read(8'h40, rd);
    chk("unmapped", 32'h0, rd);
    buf_overflow_i <= 1'b1;
    settle(2);
    chk("ovf", 32'h1, alarm_o[ALM_OVF]);
    chk("general", 32'h1, gen);
    wb_read(ADDR_CNT_LO, rd);
    chk("count", 32'h1, rd & 32'hFF);
    repeat (521) @(posedge clk_i) buf_overflow_i <= ~buf_overflow_i;
    wb_read(ADDR_CNT_LO, rd);
    chk("count", 32'hFF, rd & 32'hFF);
    wb_write(ADDR_CLR, 32'h1);
    wb_read(ADDR_CNT_LO, rd);
    chk("count", 32'h0, rd & 32'hFF);
    chk("general", 32'h0, gen);
    // boundary levels of each rate window; last entry uses the internal clock
    for (int i = 0; i < 10; i++) begin
      wb_write(ADDR_CTRL, {26'h0, 1'b0, rt_t[i], i < 9, 2'h0});
      buf_level_i <= lv_t[i];
      settle(2);
      chk("clk_lock", al_t[i], alarm_o[ALM_CLK]);
      chk("setpoint", sp_exp(rt_t[i]), sp);
    end
    wb_write(ADDR_CTRL, 32'h1);
    synth_fault_i <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      wb_write(ADDR_MODE, 32'(m) << (2 * ALM_SYN));
      settle(2);
      exp_a = (m == 0 || m == 2);
      chk("synth", exp_a, alarm_o[ALM_SYN]);
      chk("lband_en", !exp_a, lband);
    end
    synth_fault_i <= 1'b0;
    wb_write(ADDR_MODE, 32'h4000);
    wb_write(ADDR_MODE, 32'h4000);
    settle(3);
    chk("nv_pulses", 32'h4, nv_cnt);
    chk("nv_data", 32'h4000, nvdata);
    wb_write(ADDR_CTRL, 32'h0);
    rf_osc_unlock_i <= 1'b1;
    settle(2);
    chk("rf_osc", 32'h0, alarm_o[ALM_RFO]);
    wb_write(ADDR_CTRL, 32'h2);
    settle(2);
    chk("rf_osc", 32'h1, alarm_o[ALM_RFO]);
    chk("rf_en", 32'h0, rfen);
    rf_osc_unlock_i <= 1'b0;
    settle(2);
    chk("rf_en", 32'h1, rfen);
    // an answer in mid-run restarts the miss count
    wb_write(ADDR_CTRL, 32'h22);
    odu_req(1'b1, 11);
    odu_req(1'b0, 1);
    odu_req(1'b1, 11);
    settle(5);
    chk("link", 32'h0, alarm_o[ALM_ODUL]);
    odu_req(1'b1, 1);
    settle(5);
    chk("link", 32'h1, alarm_o[ALM_ODUL]);
    chk("rf_en", 32'h0, rfen);
    wb_write(ADDR_CTRL, 32'h2);
    settle(3);
    chk("link", 32'h0, alarm_o[ALM_ODUL]);
    odu_mismatch_i <= 1'b1;
    settle(3);
    chk("fprint", 32'h1, alarm_o[ALM_FP]);
    odu_mismatch_i <= 1'b0;
    settle(3);
    chk("fprint", 32'h1, alarm_o[ALM_FP]);
    wb_write(ADDR_CLR, 32'h100);
    settle(3);
    chk("fprint", 32'h0, alarm_o[ALM_FP]);
    chk("img_save", 32'h1, img_cnt);
    odu_alarms_i <= 8'h80;
    assembly_mismatch_i <= 1'b1;
    settle(2);
    chk("summary", 32'h1, alarm_o[ALM_SUM]);
    chk("asm", 32'h0, alarm_o[ALM_ASM]);
    odu_alarms_i <= 8'h00;
    settle(2);
    chk("summary", 32'h0, alarm_o[ALM_SUM]);
    chk("general", 32'h0, gen);
    wb_write(ADDR_CTRL, 32'h23);
    wb_write(ADDR_PROF, 32'h12F);
    wb_write(ADDR_CTRL, 32'h0);
    wb_write(ADDR_PROF, 32'h22F);
    wb_read(ADDR_CTRL, rd);
    chk("ctrl", 32'h20, rd);
    wb_read(ADDR_PROF, rd);
    chk("last", 32'h2F, rd & 32'h3F);
    wb_write(ADDR_PROF, 32'h205);
    wb_read(ADDR_PROF, rd);
    chk("load_err", 32'h22F, rd & 32'h23F);
    wb_write(ADDR_CTRL, 32'h3);
    wb_write(ADDR_PROF, 32'h100);
    wb_write(ADDR_CTRL, 32'h0);
    @(posedge clk_i);
    reboot_i <= 1'b1;
    @(posedge clk_i);
    reboot_i <= 1'b0;
    settle(3);
    chk("lband_en", 32'h1, lband);
    chk("rf_en", 32'h1, rfen);
    wb_read(ADDR_PROF, rd);
    chk("last", 32'h0, rd & 32'h3F);
    wb_read(ADDR_MODE, rd);
    chk("mode", 32'h4000, rd);
    chk("nv_pulses", 32'h4, nv_cnt);
    wb_write(ADDR_MODE, 32'h0);
    settle(2);
    chk("asm", 32'h1, alarm_o[ALM_ASM]);
    chk("general", 32'h1, gen);
    end_of_test();
  end
  // whole run needs about 800 cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    end_of_test();
  end
endmodule
